// ---- rtl/bgfp_pkg.sv ----
// package: constants, types and register map of the gpio and flow-pin controller
//
// What this block does
// - each of sixteen pins is input, open-drain output or push-pull output
// - after reset every pin is an input
// - open-drain high releases pin to pull-up; both modes drive low alike
// - port n: pin 4n tx toggle, 4n+1 rx toggle, 4n+2 rs-485, 4n+3 clock
// - four clock outputs, each 40 MHz base over its own 8-bit divider
// - divider one is invalid; divider zero gives 156 kHz
// - clock drives pin after enumeration and suspend exit; stops in suspend
// - clock outputs are derived by dividing the core clock
// - activity toggle rests high when idle, toggles at fixed rate when busy
// - rs-485 pin asserted while transmitting data or a line break
// - rs-485 pin active high by default, configurable active low
// - rts/cts handshake only on ports with flow control enabled
// - rts low while receive fill below 1536 bytes, high at watermark
// - after cts goes high at most two more bytes are sent
// - separate tx and rx flush options on handle open and on close
// - default: flush all on open, keep all on close
// - break holds rs-485 asserted from set-break until clear-break
package bgfp_pkg;

  localparam int NPORT   = 4;
  localparam int NPIN    = 16;
  localparam int FILL_W  = 12;
  localparam int CLK_KHZ = 50000;

  // register byte offsets
  localparam logic [7:0] OFF_PIN_MODE = 8'h00;
  localparam logic [7:0] OFF_PIN_OUT  = 8'h04;
  localparam logic [7:0] OFF_PIN_ALT  = 8'h08;
  localparam logic [7:0] OFF_PIN_IN   = 8'h0C;
  localparam logic [7:0] OFF_CLK_DIV  = 8'h10;
  localparam logic [7:0] OFF_PORT_CFG = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;

  // port_cfg field positions, one bit per port
  localparam int CFG_FLOW     = 0;
  localparam int CFG_485_LOW  = 4;
  localparam int CFG_OPEN_TX  = 8;
  localparam int CFG_OPEN_RX  = 12;
  localparam int CFG_CLOSE_TX = 16;
  localparam int CFG_CLOSE_RX = 20;

  // reset values
  localparam logic [31:0] PIN_MODE_RST = 32'h0000_0000;
  localparam logic [15:0] PIN_OUT_RST  = 16'h0000;
  localparam logic [15:0] PIN_ALT_RST  = 16'h0000;
  localparam logic [31:0] CLK_DIV_RST  = 32'h0000_0000;
  localparam logic [23:0] PORT_CFG_RST = 24'h00_FF00;

  // activity toggle half period, picked for visible blinking
  localparam int TOGGLE_HALF_MS = 50;
  localparam int TOGGLE_CYC     = TOGGLE_HALF_MS * CLK_KHZ;
  localparam int WATERMARK_B    = 1536;
  localparam int CTS_SLACK      = 2;
  localparam int BASE_MHZ       = 40;
  localparam int CORE_MHZ       = CLK_KHZ / 1000;

  typedef enum logic [1:0] {PM_IN, PM_OD, PM_PP, PM_RSV} bgfp_pin_mode_t;

  typedef struct packed {
    logic              tx_active;
    logic              rx_active;
    logic              tx_byte_start;
    logic              set_break;
    logic              clear_break;
    logic              handle_open;
    logic              handle_close;
    logic              cts_n;
    logic [FILL_W-1:0] rx_fill;
  } bgfp_port_in_t;

  typedef struct packed {
    logic rts_n;
    logic tx_allow;
    logic flush_tx;
    logic flush_rx;
  } bgfp_port_out_t;

  localparam bgfp_port_out_t PORT_OUT_RST = '{rts_n: 1'b0, tx_allow: 1'b1, flush_tx: 1'b0, flush_rx: 1'b0};

endpackage : bgfp_pkg

// ---- rtl/bgfp_clk_div.sv ----
// clock output divider: 40 MHz tick from the core clock, then 8-bit divide
`timescale 1ns/1ps
`default_nettype none
module bgfp_clk_div #(
  parameter int BASE = 40,
  parameter int CORE = 50
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [7:0] div,
  output var  logic       clk_o
);
  import bgfp_pkg::*;

  logic [7:0] acc;
  logic [8:0] cnt;
  logic [8:0] period;
  logic [8:0] next_cnt;
  logic       tick;

  // zero stands for 256, which lands on 156 kHz
  assign period = (div == 8'h00) ? 9'h100 : {1'b0, div};
  assign tick   = (9'(acc) + 9'(BASE)) >= 9'(CORE);
  assign next_cnt = (cnt >= period - 9'h001) ? 9'h000 : cnt + 9'h001;

  // base ticks come from a phase accumulator on the core clock, so edges
  // jitter by one core cycle but the mean rate is exact
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 8'h00;
    else if (tick)
      acc <= 8'(9'(acc) + 9'(BASE) - 9'(CORE));
    else
      acc <= 8'(9'(acc) + 9'(BASE));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt   <= 9'h000;
      clk_o <= 1'b0;
    end
    else if (!run)
    begin
      cnt   <= 9'h000;
      clk_o <= 1'b0;
    end
    else if (tick)
    begin
      cnt   <= next_cnt;
      clk_o <= next_cnt < (period >> 1);
    end
  end

endmodule : bgfp_clk_div
`default_nettype wire

// ---- rtl/bgfp_top.sv ----
// gpio, alternate pin functions and rts/cts flow control with apb registers
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bgfp_top
  import bgfp_pkg::*;
#(
  parameter int WATERMARK     = WATERMARK_B,
  parameter int TOGGLE_CYCLES = TOGGLE_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  input  wire logic                     usb_configured,
  input  wire logic                     usb_suspend,
  input  wire bgfp_pkg::bgfp_port_in_t  [NPORT-1:0] port_in,
  output var  bgfp_pkg::bgfp_port_out_t [NPORT-1:0] port_out,
  input  wire logic [NPIN-1:0]          gpio_in,
  output var  logic [NPIN-1:0]          gpio_out,
  output var  logic [NPIN-1:0]          gpio_oe
);
  import bgfp_pkg::*;

  localparam int TW = $clog2(TOGGLE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////
  // registers and apb slave

  logic [31:0] pin_mode;
  logic [15:0] pin_out;
  logic [15:0] pin_alt;
  logic [15:0] pin_in;
  logic [31:0] clk_div;
  logic [23:0] port_cfg;
  logic [31:0] rd_mux;
  logic        wr_fire;
  logic        acc_phase;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_PIN_MODE) || (a == OFF_PIN_OUT) || (a == OFF_PIN_ALT) ||
              (a == OFF_PIN_IN) || (a == OFF_CLK_DIV) || (a == OFF_PORT_CFG) ||
              (a == OFF_STATUS);
  endfunction : reg_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        merge[8*b +: 8] = nw[8*b +: 8];
  endfunction : merge

  logic [NPORT-1:0] brk;
  logic [1:0]       sent [NPORT];
  logic [1:0]       next_sent [NPORT];
  logic [NPORT-1:0] flow_en;
  logic [NPORT-1:0] low_485;
  logic [NPORT-1:0] cts_n_v;
  logic [NPORT-1:0] rts_v;
  logic [NPORT-1:0] allow_v;

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      flow_en[p] = port_cfg[CFG_FLOW + p];
      low_485[p] = port_cfg[CFG_485_LOW + p];
      cts_n_v[p] = port_in[p].cts_n;
      rts_v[p]   = port_out[p].rts_n;
      allow_v[p] = port_out[p].tx_allow;
    end
  end

  assign acc_phase = psel && penable;
  assign wr_fire   = acc_phase && pready && pwrite && reg_hit(paddr);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_PIN_MODE: rd_mux = pin_mode;
      OFF_PIN_OUT:  rd_mux = {16'h0000, pin_out};
      OFF_PIN_ALT:  rd_mux = {16'h0000, pin_alt};
      OFF_PIN_IN:   rd_mux = {16'h0000, pin_in};
      OFF_CLK_DIV:  rd_mux = clk_div;
      OFF_PORT_CFG: rd_mux = {8'h00, port_cfg};
      OFF_STATUS:   rd_mux = {16'h0000, brk, allow_v, rts_v, cts_n_v};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state keeps prdata and pready straight from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_phase && !pready;
      pslverr <= acc_phase && !pready && !reg_hit(paddr);
      prdata  <= (acc_phase && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_mode <= PIN_MODE_RST;
      pin_out  <= PIN_OUT_RST;
      pin_alt  <= PIN_ALT_RST;
      port_cfg <= PORT_CFG_RST;
    end
    else if (wr_fire)
    begin
      if (paddr == OFF_PIN_MODE)
        pin_mode <= merge(pin_mode, pwdata, pstrb);
      if (paddr == OFF_PIN_OUT)
        pin_out <= 16'(merge({16'h0000, pin_out}, pwdata, pstrb));
      if (paddr == OFF_PIN_ALT)
        pin_alt <= 16'(merge({16'h0000, pin_alt}, pwdata, pstrb));
      if (paddr == OFF_PORT_CFG)
        port_cfg <= 24'(merge({8'h00, port_cfg}, pwdata, pstrb));
    end
  end

  // a divider byte of one is refused and the old value kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_div <= CLK_DIV_RST;
    else if (wr_fire && paddr == OFF_CLK_DIV)
    begin
      for (int b = 0; b < 4; b++)
        if (pstrb[b] && pwdata[8*b +: 8] != 8'h01)
          clk_div[8*b +: 8] <= pwdata[8*b +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_in <= 16'h0000;
    else
      pin_in <= gpio_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port alternate functions

  logic             clk_run;
  logic [NPORT-1:0] clk_pin;
  logic [TW-1:0]    tcnt [NPORT][2];
  logic [1:0]       tog [NPORT];
  logic [NPIN-1:0]  alt_val;

  assign clk_run = usb_configured && !usb_suspend;

  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_clk
      bgfp_clk_div #(
        .BASE (BASE_MHZ),
        .CORE (CORE_MHZ)
      ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (clk_run),
        .div     (clk_div[8*g +: 8]),
        .clk_o   (clk_pin[g])
      );
    end
  endgenerate

  // break state runs from set-break until clear-break; set wins a tie
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brk <= '0;
    else
      for (int p = 0; p < NPORT; p++)
        if (port_in[p].set_break)
          brk[p] <= 1'b1;
        else if (port_in[p].clear_break)
          brk[p] <= 1'b0;
  end

  // idle resets the phase, so a burst always starts with the led high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        tog[p]     <= 2'b11;
        tcnt[p][0] <= '0;
        tcnt[p][1] <= '0;
      end
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
        for (int d = 0; d < 2; d++)
          if (!(d == 0 ? port_in[p].tx_active : port_in[p].rx_active))
          begin
            tog[p][d]  <= 1'b1;
            tcnt[p][d] <= '0;
          end
          else if (tcnt[p][d] == TW'(TOGGLE_CYCLES - 1))
          begin
            tog[p][d]  <= !tog[p][d];
            tcnt[p][d] <= '0;
          end
          else
            tcnt[p][d] <= tcnt[p][d] + TW'(1);
    end
  end

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      alt_val[4*p]     = tog[p][0];
      alt_val[4*p + 1] = tog[p][1];
      alt_val[4*p + 2] = (port_in[p].tx_active || brk[p]) ^ low_485[p];
      alt_val[4*p + 3] = clk_pin[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  logic [NPIN-1:0] next_gpio_out;
  logic [NPIN-1:0] next_gpio_oe;

  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      next_gpio_out[i] = 1'b0;
      next_gpio_oe[i]  = 1'b0;
      if (pin_alt[i])
      begin
        next_gpio_out[i] = alt_val[i];
        next_gpio_oe[i]  = (i % 4 == 3) ? clk_run : 1'b1;
      end
      else
        unique case (bgfp_pin_mode_t'(pin_mode[2*i +: 2]))
          PM_OD:
          begin
            next_gpio_out[i] = 1'b0;
            next_gpio_oe[i]  = !pin_out[i];
          end
          PM_PP:
          begin
            next_gpio_out[i] = pin_out[i];
            next_gpio_oe[i]  = 1'b1;
          end
          default:
          begin
            next_gpio_out[i] = 1'b0;
            next_gpio_oe[i]  = 1'b0;
          end
        endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_out <= '0;
      gpio_oe  <= '0;
    end
    else
    begin
      gpio_out <= next_gpio_out;
      gpio_oe  <= next_gpio_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flow control and flush

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      next_sent[p] = sent[p];
      if (!flow_en[p] || !port_in[p].cts_n)
        next_sent[p] = 2'b00;
      else if (port_in[p].tx_byte_start && sent[p] != 2'(CTS_SLACK))
        next_sent[p] = sent[p] + 2'b01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int p = 0; p < NPORT; p++)
        sent[p] <= 2'b00;
    else
      for (int p = 0; p < NPORT; p++)
        sent[p] <= next_sent[p];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_out <= {NPORT{PORT_OUT_RST}};
    else
      for (int p = 0; p < NPORT; p++)
      begin
        port_out[p].rts_n <= flow_en[p] && (32'(port_in[p].rx_fill) >= WATERMARK);
        port_out[p].tx_allow <= !flow_en[p] || !port_in[p].cts_n ||
                                next_sent[p] < 2'(CTS_SLACK);
        port_out[p].flush_tx <= (port_in[p].handle_open && port_cfg[CFG_OPEN_TX + p]) ||
                                (port_in[p].handle_close && port_cfg[CFG_CLOSE_TX + p]);
        port_out[p].flush_rx <= (port_in[p].handle_open && port_cfg[CFG_OPEN_RX + p]) ||
                                (port_in[p].handle_close && port_cfg[CFG_CLOSE_RX + p]);
      end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [NPIN-1:0] want_in;
  logic [NPIN-1:0] od_high;
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
    begin
      want_in[i] = !pin_alt[i] && (pin_mode[2*i +: 2] == 2'b00 || pin_mode[2*i +: 2] == 2'b11);
      od_high[i] = !pin_alt[i] && pin_mode[2*i +: 2] == 2'b01 && pin_out[i];
    end
  end

  property p_input_float;
    1'b1 |=> (gpio_oe & $past(want_in)) == '0;
  endproperty
  a_input_float: assert property (p_input_float) else $error("input pin driven");

  property p_od_release;
    |od_high |=> (gpio_oe & $past(od_high)) == '0;
  endproperty
  a_od_release: assert property (p_od_release) else $error("open-drain high driven");

  property p_div_legal;
    (clk_div[7:0] != 8'h01) && (clk_div[15:8] != 8'h01) &&
    (clk_div[23:16] != 8'h01) && (clk_div[31:24] != 8'h01);
  endproperty
  a_div_legal: assert property (p_div_legal) else $error("divider of one held");

  property p_clk_suspend;
    usb_suspend && pin_alt[3] |=> !gpio_oe[3];
  endproperty
  a_clk_suspend: assert property (p_clk_suspend) else $error("clock pin driven in suspend");

  property p_break_hold;
    port_in[0].set_break ##1 (!port_in[0].clear_break)[*2] |-> brk[0] && (alt_val[2] != low_485[0]);
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("rs-485 dropped during break");

  property p_rts_wm;
    flow_en[0] && $stable(flow_en[0]) && (32'(port_in[0].rx_fill) >= WATERMARK) |=> port_out[0].rts_n;
  endproperty
  a_rts_wm: assert property (p_rts_wm) else $error("rts low at watermark");

  property p_cts_two;
    flow_en[0] && port_in[0].cts_n && sent[0] == 2'b10 |=> !port_out[0].tx_allow;
  endproperty
  a_cts_two: assert property (p_cts_two) else $error("third byte allowed under cts");

  property p_idle_high;
    (!port_in[0].tx_active)[*2] |-> tog[0][0];
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("tx toggle low while idle");

endmodule : bgfp_top
`default_nettype wire

// ---- dv/bgfp_far_dev.sv ----
// far-side model: serial peer on port 0 plus the pin pull-ups
`timescale 1ns/1ps
`default_nettype none
module bgfp_far_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rts_n,
  input  wire logic        cts_hold,
  input  wire logic        sending,
  input  wire logic        fill_set,
  input  wire logic [11:0] fill_val,
  input  wire logic [15:0] gpio_out,
  input  wire logic [15:0] gpio_oe,
  output var  logic        cts_n,
  output var  logic [11:0] rx_fill,
  output var  logic [15:0] gpio_in
);
  logic [1:0] gap;
  ////////////////////////////////////////
  // a released pin floats up to io_supply_rail; low is the same in both modes
  assign gpio_in = (gpio_out & gpio_oe) | ~gpio_oe;
  ////////////////////////////////////////
  // one byte every four cycles, so one in flight at most once rts rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap     <= 2'h0;
      rx_fill <= 12'h000;
      cts_n   <= 1'b0;
    end
    else
    begin
      gap   <= gap + 2'h1;
      cts_n <= cts_hold;
      if (fill_set)
        rx_fill <= fill_val;
      else if (sending && !rts_n && gap == 2'h3)
        rx_fill <= rx_fill + 12'h001;
    end
  end
endmodule : bgfp_far_dev
`default_nettype wire

// ---- dv/bgfp_top_test.sv ----
// self-checking bench for the gpio and flow-pin controller
`timescale 1ns/1ps
`default_nettype none
module bgfp_top_test;
  import bgfp_pkg::*;
  localparam int TOG = 8;
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]                 paddr;
  logic [31:0]                pwdata, prdata;
  logic [3:0]                 pstrb;
  logic                       usb_configured, usb_suspend;
  bgfp_port_in_t  [NPORT-1:0] pin_tb, port_in;
  bgfp_port_out_t [NPORT-1:0] port_out;
  logic [NPIN-1:0]            gpio_in, gpio_out, gpio_oe;
  logic                       cts_hold, sending, fill_set, far_cts_n;
  logic [11:0]                fill_val, far_fill;
  int                         mismatches, compares;
  ////////////////////////////////////////
  always_comb
  begin
    port_in            = pin_tb;
    port_in[0].cts_n   = far_cts_n;
    port_in[0].rx_fill = far_fill;
  end
  bgfp_top #(.WATERMARK(1536), .TOGGLE_CYCLES(TOG)) i_bgfp_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_configured(usb_configured),
    .usb_suspend(usb_suspend), .port_in(port_in), .port_out(port_out), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  bgfp_far_dev i_bgfp_far_dev (.pclk(pclk), .presetn(presetn), .rts_n(port_out[0].rts_n),
    .cts_hold(cts_hold), .sending(sending), .fill_set(fill_set), .fill_val(fill_val),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .cts_n(far_cts_n), .rx_fill(far_fill), .gpio_in(gpio_in));
  ////////////////////////////////////////
  task chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task close_out;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    chk(pready === 1'b1, "no pready");
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e === 1'b0, "write refused");
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r === x && e === xe, "read mismatch");
  endtask : rd
  task pulse_chk(input logic opn, input logic cls, input logic etx, input logic erx);
    @(posedge pclk);
    pin_tb[0].handle_open <= opn; pin_tb[0].handle_close <= cls;
    @(posedge pclk);
    pin_tb[0].handle_open <= 1'b0; pin_tb[0].handle_close <= 1'b0;
    #1;
    chk(port_out[0].flush_tx === etx && port_out[0].flush_rx === erx, "flush pulse");
  endtask : pulse_chk
  task edges(input int pin, input int n, output int rises, output int chg);
    logic last;
    last = gpio_out[pin]; rises = 0; chg = 0;
    repeat (n)
    begin
      @(posedge pclk); #1;
      if (gpio_out[pin] !== last)
      begin
        chg++;
        if (gpio_out[pin] === 1'b1) rises++;
      end
      last = gpio_out[pin];
    end
  endtask : edges
  ////////////////////////////////////////
  task t_reset;
    chk(gpio_oe === 16'h0000, "pins not inputs");
    rd(OFF_PIN_MODE, 32'h0000_0000, 1'b0);
    rd(OFF_PORT_CFG, 32'h0000_FF00, 1'b0);
    rd(8'h40, 32'h0000_0000, 1'b1);
    chk(port_out[0].rts_n === 1'b0 && port_out[0].tx_allow === 1'b1, "flow idle");
  endtask : t_reset
  // pin0 push-pull, pin1 open-drain, pin2 input, pin3 reserved code
  task t_modes;
    wr(OFF_PIN_MODE, 32'h0000_00C6);
    wr(OFF_PIN_OUT, 32'h0000_0003);
    cyc(3);
    chk(gpio_oe[3:0] === 4'b0001 && gpio_out[0] === 1'b1, "drive high");
    rd(OFF_PIN_IN, 32'h0000_FFFF, 1'b0);
    wr(OFF_PIN_OUT, 32'h0000_0000);
    cyc(3);
    chk(gpio_oe[3:0] === 4'b0011 && gpio_out[1:0] === 2'b00, "drive low");
    rd(OFF_PIN_IN, 32'h0000_FFFC, 1'b0);
  endtask : t_modes
  task t_flush;
    pulse_chk(1'b1, 1'b0, 1'b1, 1'b1);
    pulse_chk(1'b0, 1'b1, 1'b0, 1'b0);
    wr(OFF_PORT_CFG, 32'h0001_0000);
    pin_tb[0].tx_active <= 1'b1;
    pulse_chk(1'b0, 1'b1, 1'b1, 1'b0);
    pulse_chk(1'b1, 1'b0, 1'b0, 1'b0);
    pin_tb[0].tx_active <= 1'b0;
    wr(OFF_PORT_CFG, 32'h0000_FF00);
  endtask : t_flush
  task t_rs485;
    wr(OFF_PIN_MODE, 32'hAAAA_AAAA);
    wr(OFF_PIN_ALT, 32'h0000_FFFF);
    for (int p = 0; p < NPORT; p++)
    begin
      @(posedge pclk); pin_tb[p].tx_active <= 1'b1;
      cyc(3);
      chk((gpio_out & 16'h4444) === (16'h0004 << (4 * p)), "rs485 pin");
      @(posedge pclk); pin_tb[p].tx_active <= 1'b0;
    end
    @(posedge pclk); pin_tb[0].set_break <= 1'b1;
    @(posedge pclk); pin_tb[0].set_break <= 1'b0;
    cyc(6);
    chk(gpio_out[2] === 1'b1, "break hold");
    @(posedge pclk); pin_tb[0].clear_break <= 1'b1;
    @(posedge pclk); pin_tb[0].clear_break <= 1'b0;
    cyc(3);
    chk(gpio_out[2] === 1'b0, "break end");
    wr(OFF_PORT_CFG, 32'h0000_FF10);
    cyc(3);
    chk(gpio_out[2] === 1'b1, "inverted idle");
    @(posedge pclk); pin_tb[0].tx_active <= 1'b1;
    cyc(3);
    chk(gpio_out[2] === 1'b0, "inverted active");
    @(posedge pclk); pin_tb[0].tx_active <= 1'b0;
    wr(OFF_PORT_CFG, 32'h0000_FF00);
  endtask : t_rs485
  task t_toggle;
    int r, c;
    for (int d = 0; d < 2; d++)
    begin
      cyc(2);
      chk(gpio_out[d] === 1'b1, "toggle idle");
      @(posedge pclk);
      if (d == 0) pin_tb[0].tx_active <= 1'b1;
      else pin_tb[0].rx_active <= 1'b1;
      edges(d, 10 * TOG, r, c);
      chk(c >= 9 && c <= 11, "toggle rate");
      @(posedge pclk); pin_tb[0].tx_active <= 1'b0; pin_tb[0].rx_active <= 1'b0;
    end
    cyc(3);
    chk(gpio_out[1:0] === 2'b11, "toggle back idle");
  endtask : t_toggle
  task t_clock;
    int r, c, x;
    wr(OFF_CLK_DIV, 32'h0000_0004);
    chk((gpio_oe & 16'h8888) === 16'h0000, "clock before enumeration");
    @(posedge pclk); usb_configured <= 1'b1;
    cyc(3);
    chk((gpio_oe & 16'h8888) === 16'h8888, "clock pins driven");
    x = 1000 * BASE_MHZ / (CORE_MHZ * 4);
    edges(3, 1000, r, c);
    chk(r >= x - 2 && r <= x + 2, "clock rate");
    wr(OFF_CLK_DIV, 32'h0000_0001);
    rd(OFF_CLK_DIV, 32'h0000_0004, 1'b0);
    wr(OFF_CLK_DIV, 32'h0000_0000);
    x = 4000 * BASE_MHZ / (CORE_MHZ * 256);
    edges(3, 4000, r, c);
    chk(r >= x - 1 && r <= x + 2, "clock zero divider");
    @(posedge pclk); usb_suspend <= 1'b1;
    cyc(3);
    chk((gpio_oe & 16'h8888) === 16'h0000, "clock off in suspend");
  endtask : t_clock
  task t_flow;
    int n;
    n = 0;
    wr(OFF_PORT_CFG, 32'h0000_FF01);
    @(posedge pclk); fill_set <= 1'b1; fill_val <= 12'd1530;
    @(posedge pclk); fill_set <= 1'b0; sending <= 1'b1;
    cyc(80);
    chk(port_out[0].rts_n === 1'b1, "rts at watermark");
    chk(far_fill >= 12'd1536 && far_fill <= 12'd1537, "peer held off");
    @(posedge pclk); sending <= 1'b0; fill_set <= 1'b1; fill_val <= 12'd1535;
    @(posedge pclk); fill_set <= 1'b0;
    cyc(3);
    chk(port_out[0].rts_n === 1'b0, "rts below watermark");
    @(posedge pclk); cts_hold <= 1'b1;
    cyc(4);
    repeat (5)
    begin
      @(posedge pclk);
      if (port_out[0].tx_allow === 1'b1)
      begin
        pin_tb[0].tx_byte_start <= 1'b1;
        n++;
      end
      @(posedge pclk); pin_tb[0].tx_byte_start <= 1'b0;
      @(posedge pclk);
    end
    chk(n == CTS_SLACK && port_out[0].tx_allow === 1'b0, "bytes after cts");
    rd(OFF_STATUS, 32'h0000_0E01, 1'b0);
    @(posedge pclk); cts_hold <= 1'b0;
    cyc(4);
    chk(port_out[0].tx_allow === 1'b1, "cts cleared");
    wr(OFF_PORT_CFG, 32'h0000_FF00);
    @(posedge pclk); cts_hold <= 1'b1; fill_set <= 1'b1; fill_val <= 12'd1600;
    @(posedge pclk); fill_set <= 1'b0;
    cyc(4);
    chk(port_out[0].rts_n === 1'b0 && port_out[0].tx_allow === 1'b1, "flow off");
  endtask : t_flow
  ////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    #400_000;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    close_out;
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; pstrb = 4'h0; usb_configured = 1'b0; usb_suspend = 1'b0;
    pin_tb = '0; cts_hold = 1'b0; sending = 1'b0; fill_set = 1'b0; fill_val = 12'h000;
    mismatches = 0; compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_modes;
    t_flush;
    t_rs485;
    t_toggle;
    t_clock;
    t_flow;
    close_out;
  end
endmodule : bgfp_top_test
`default_nettype wire
